/* File: design/srctl_pkg.sv */
// constants and types shared by the system reset controller files
// How it works
// - pin low or watchdog overflow, same reset
// - start at vector in bytes 0000/0001
// - pins high impedance through reset and stabilization
// - pin release waits 2^15 clocks before run
// - watchdog reset self-clears, same 2^15 wait
// - stop reset keeps contents while the pin is held, pins still float
// - pc undefined until released, rest preset
// - status word 02, stack pointer undefined
// - ram undefined, kept when reset in standby
// - latches 00, directions ff, pull-ups cleared
// - clock registers 02/00/00, stabilize select 04
// - timer registers cleared, byte compare undefined
// - watch, watchdog, clock output cleared
// - serial registers cleared, transmit shift ones, receive undefined
// - display and alternate function cleared
// - request flags cleared, masks all set
package srctl_pkg;
    // clock and stabilization timing
    localparam int CLK_MHZ = 100;            // main clock rate
    localparam int STAB_FX_PERIODS = 32768;  // 2^15 periods of the main clock
    localparam int CLK_PER_FX = 1;           // the block runs on the main clock itself
    localparam int STAB_CYCLES_DEF = STAB_FX_PERIODS * CLK_PER_FX;
    localparam int STAB_CNT_W = 16;          // counter width for the wait

    // reset vector bytes
    localparam logic [15:0] VEC_LO = 16'h0000;
    localparam logic [15:0] VEC_HI = 16'h0001;

    // register bank: index is the byte offset on the register port
    localparam int NREG = 45;
    localparam logic [7:0] OFF_PSW = 8'h00;
    localparam logic [7:0] OFF_PORT0_DIR = 8'h09;
    localparam logic [7:0] OFF_OSC_STABILIZE_SELECT = 8'h13;
    localparam logic [7:0] OFF_TXS = 8'h21;
    localparam logic [7:0] OFF_LAST = 8'h2C;
    localparam logic [7:0] OFF_STATUS = 8'h40;   // read-only block state
    localparam logic [7:0] OFF_CAUSE_CLR = 8'h41; // write ones to clear cause flags

    // status register field positions
    localparam int ST_CAUSE_PIN = 0;
    localparam int ST_CAUSE_WDT = 1;
    localparam int ST_STOP_HOLD = 2;
    localparam int ST_RAM_HOLD = 3;

    // values loaded on reset, index order of the bank
    localparam logic [7:0] RST_VAL [NREG] = '{
        8'h02,                                  // program_status_word
        8'h00, 8'h00,                           // stack pointer low/high (kept)
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, // port output latches 0..5
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, // port0_direction .. port5
        8'h00,                                  // pullup_option
        8'h02, 8'h00, 8'h00, 8'h04,             // processor_clock_ctrl .. osc_stabilize_select
        8'h00, 8'h00, 8'h00,                    // wide_timer_compare lo/hi, wide_timer_ctrl
        8'h00, 8'h00, 8'h00,                    // byte_timer_count, _compare (kept), _mode
        8'h00, 8'h00, 8'h00, 8'h00,             // watch_timer_mode .. clock_output_ctrl
        8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,      // async serial, baud, transmit_shift, receive
        8'h00, 8'h00, 8'h00,                    // display_mode, alt_port_function_switch, clock
        8'h00, 8'h00, 8'hFF, 8'hFF,             // irq request low/high, irq mask low/high
        8'h00, 8'h00, 8'h00                     // ext_irq_mode_a/b, key_return_mode
    };
    // entries that reset leaves untouched (undefined after reset)
    localparam bit KEEP [NREG] = '{
        0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0,
        0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0,
        0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0
    };

    // sequencer states
    typedef enum logic [2:0] {
        SRCTL_HOLD,
        SRCTL_STAB,
        SRCTL_FETCH_LO,
        SRCTL_FETCH_HI,
        SRCTL_FETCH_END,
        SRCTL_RUN
    } srctl_state_type;
endpackage

/* File: design/srctl_stab_if.sv */
// handshake between the sequencer and the stabilization timer
`timescale 1ns/1ps
interface srctl_stab_if;
    logic start; // one-cycle pulse, restarts the wait
    logic busy;  // wait in progress
    logic done;  // one-cycle pulse when the wait has elapsed
    modport ctrl (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface

/* File: design/srctl_sync3.sv */
// three-stage synchronizer with agreement filter for the reset pin
`timescale 1ns/1ps
module srctl_sync3 (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic d_in,
    output logic q_out
);
    // all stages of the chain in one state word
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } srctl_sync_type;

    srctl_sync_type s_r;
    srctl_sync_type s_nxt;

    // shift chain; the output moves only when stages two and three agree
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = d_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        if (s_r.s2 == s_r.s3) begin
            s_nxt.q = s_r.s3;
        end
    end

    // reset reads as pin low, so nothing runs before the pin is seen high
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.q;

    a_sync_agree: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_r.q != $past(s_r.q)) |-> ($past(s_r.s2) == $past(s_r.s3)))
        else $error("synchronized pin changed without stage agreement");
endmodule

/* File: design/srctl_stab_timer.sv */
// oscillation stabilization wait counter, restartable
`timescale 1ns/1ps
module srctl_stab_timer #(
    parameter int STAB_CYCLES = srctl_pkg::STAB_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    srctl_stab_if.timer stab
);
    typedef struct packed {
        logic [srctl_pkg::STAB_CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } srctl_timer_type;

    srctl_timer_type s_r;
    srctl_timer_type s_nxt;
    logic [31:0] seen_r; // helper: busy cycles since the last start

    // a start always reloads, so a new reset mid-wait begins a full wait
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (stab.start) begin
            s_nxt.cnt = srctl_pkg::STAB_CNT_W'(STAB_CYCLES - 1);
            s_nxt.busy = 1'b1;
        end else if (s_r.busy) begin
            if (s_r.cnt == '0) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end
        end
    end

    // counter state
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign stab.busy = s_r.busy;
    assign stab.done = s_r.done;

    // helper count of the wait as actually served
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            seen_r <= '0;
        end else if (stab.start) begin
            seen_r <= '0;
        end else if (s_r.busy) begin
            seen_r <= seen_r + 1'b1;
        end
    end

    a_stab_length: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        s_r.done |-> (seen_r == 32'(STAB_CYCLES)))
        else $error("stabilization wait not of the full length");

    a_stab_restart: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        stab.start |=> (s_r.busy && !s_r.done))
        else $error("start did not restart the wait");
endmodule

/* File: design/srctl_top.sv */
// system reset controller: merges reset sources, times release, presets registers
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module srctl_top #(
    parameter int STAB_CYCLES = srctl_pkg::STAB_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic reset_pin_b_in,      // external reset pin, asynchronous
    input wire logic wdt_overflow_in,     // watchdog overflow pulse, same clock
    input wire logic stop_mode_in,        // core is in stop standby
    input wire logic halt_mode_in,        // core is in halt standby
    input wire logic [7:0] mem_data_in,   // program memory byte, cycle after read
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic sys_reset_b_out,         // low while peripherals are held in reset
    output logic pins_hiz_out,            // all pins released to high impedance
    output logic cpu_run_out,             // cpu executes
    output logic pc_valid_out,            // program counter holds a defined value
    output logic [15:0] pc_out,
    output logic mem_rd_out,
    output logic [15:0] mem_addr_out,
    output logic ram_hold_out             // ram contents are to be kept
);
    // whole state of the controller
    typedef struct packed {
        srctl_pkg::srctl_state_type state;
        logic cause_pin;
        logic cause_wdt;
        logic stop_hold;
        logic ram_hold;
        logic [srctl_pkg::NREG-1:0][7:0] regs;
        logic [15:0] pc;
        logic pc_valid;
        logic [7:0] rdata;
        logic sys_reset_b;
        logic pins_hiz;
        logic cpu_run;
        logic mem_rd;
        logic [15:0] mem_addr;
        logic timer_start;
    } srctl_ctl_type;

    srctl_ctl_type s_r;
    srctl_ctl_type s_nxt;
    logic pin_b_sync; // filtered pin level
    logic pin_low;
    logic reset_req;  // any reset source active this cycle

    srctl_stab_if stab ();

    // pin crosses into the clock domain before anything looks at it
    srctl_sync3 u_pin_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .d_in(reset_pin_b_in),
        .q_out(pin_b_sync)
    );

    // stabilization wait
    srctl_stab_timer #(.STAB_CYCLES(STAB_CYCLES)) u_stab (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .stab(stab.timer)
    );

    assign stab.start = s_r.timer_start;
    assign pin_low = !pin_b_sync;
    assign reset_req = pin_low || wdt_overflow_in;

    // preset every defined register; undefined ones keep whatever they hold
    function automatic logic [srctl_pkg::NREG-1:0][7:0] srctl_defaults(
        input logic [srctl_pkg::NREG-1:0][7:0] cur
    );
        logic [srctl_pkg::NREG-1:0][7:0] res;
        res = cur;
        for (int i = 0; i < srctl_pkg::NREG; i++) begin
            if (!srctl_pkg::KEEP[i]) begin
                res[i] = srctl_pkg::RST_VAL[i];
            end
        end
        return res;
    endfunction

    // next-state logic: sequencer, register port and output images
    always_comb begin
        s_nxt = s_r;
        s_nxt.timer_start = 1'b0;
        s_nxt.mem_rd = 1'b0;
        s_nxt.rdata = 8'h00;

        // register writes; a later preset in hold overrides them
        if (wr_in) begin
            if (addr_in <= srctl_pkg::OFF_LAST) begin
                s_nxt.regs[addr_in] = wdata_in;
            end else if (addr_in == srctl_pkg::OFF_CAUSE_CLR) begin
                if (wdata_in[srctl_pkg::ST_CAUSE_PIN]) begin
                    s_nxt.cause_pin = 1'b0;
                end
                if (wdata_in[srctl_pkg::ST_CAUSE_WDT]) begin
                    s_nxt.cause_wdt = 1'b0;
                end
            end
        end

        // register reads, data in the following cycle only
        if (rd_in) begin
            if (addr_in <= srctl_pkg::OFF_LAST) begin
                s_nxt.rdata = s_r.regs[addr_in];
            end else if (addr_in == srctl_pkg::OFF_STATUS) begin
                s_nxt.rdata = {s_r.state, 1'b0, s_r.ram_hold, s_r.stop_hold,
                               s_r.cause_wdt, s_r.cause_pin};
            end else begin
                s_nxt.rdata = 8'h00; // unmapped reads as zero
            end
        end

        // cause flags: a new event wins over a clear in the same cycle
        if (pin_low) begin
            s_nxt.cause_pin = 1'b1;
        end
        if (wdt_overflow_in) begin
            s_nxt.cause_wdt = 1'b1;
        end

        // sequencer: hold, wait, two vector reads, then run
        case (s_r.state)
            srctl_pkg::SRCTL_HOLD: begin
                // stop contents stay frozen while the pin is held
                if (!s_r.stop_hold) begin
                    s_nxt.regs = srctl_defaults(s_nxt.regs);
                end
                // watchdog reset needs no release; pin reset waits for the pin
                if (!pin_low) begin
                    s_nxt.regs = srctl_defaults(s_nxt.regs);
                    s_nxt.stop_hold = 1'b0;
                    s_nxt.timer_start = 1'b1;
                    s_nxt.state = srctl_pkg::SRCTL_STAB;
                end
            end

            // waiting out the oscillation; presets stay applied
            srctl_pkg::SRCTL_STAB: begin
                if (reset_req) begin
                    s_nxt.state = srctl_pkg::SRCTL_HOLD;
                end else if (stab.done) begin
                    // wait over: fetch the low vector byte
                    s_nxt.mem_rd = 1'b1;
                    s_nxt.mem_addr = srctl_pkg::VEC_LO;
                    s_nxt.state = srctl_pkg::SRCTL_FETCH_LO;
                end else begin
                    s_nxt.regs = srctl_defaults(s_nxt.regs);
                end
            end

            // low byte is being read; ask for the high byte next
            srctl_pkg::SRCTL_FETCH_LO: begin
                if (reset_req) begin
                    s_nxt.state = srctl_pkg::SRCTL_HOLD;
                end else begin
                    s_nxt.mem_rd = 1'b1;
                    s_nxt.mem_addr = srctl_pkg::VEC_HI;
                    s_nxt.state = srctl_pkg::SRCTL_FETCH_HI;
                end
            end

            // low byte answers in this cycle
            srctl_pkg::SRCTL_FETCH_HI: begin
                if (reset_req) begin
                    s_nxt.state = srctl_pkg::SRCTL_HOLD;
                end else begin
                    s_nxt.pc[7:0] = mem_data_in;
                    s_nxt.state = srctl_pkg::SRCTL_FETCH_END;
                end
            end

            // high byte answers in this cycle; run from the next edge
            srctl_pkg::SRCTL_FETCH_END: begin
                if (reset_req) begin
                    s_nxt.state = srctl_pkg::SRCTL_HOLD;
                end else begin
                    s_nxt.pc[15:8] = mem_data_in;
                    s_nxt.state = srctl_pkg::SRCTL_RUN;
                end
            end

            default: begin
                // running: any source throws the device back into hold
                if (reset_req) begin
                    s_nxt.state = srctl_pkg::SRCTL_HOLD;
                    s_nxt.stop_hold = stop_mode_in;
                    s_nxt.ram_hold = stop_mode_in || halt_mode_in;
                end
            end
        endcase

        // ram hold is only meaningful until the program runs again
        if (s_nxt.state == srctl_pkg::SRCTL_RUN) begin
            s_nxt.ram_hold = 1'b0;
        end

        // output images follow the next state so they line up with it
        s_nxt.pins_hiz = (s_nxt.state == srctl_pkg::SRCTL_HOLD) ||
                         (s_nxt.state == srctl_pkg::SRCTL_STAB);
        s_nxt.sys_reset_b = !s_nxt.pins_hiz;
        s_nxt.cpu_run = (s_nxt.state == srctl_pkg::SRCTL_RUN);
        s_nxt.pc_valid = s_nxt.cpu_run;
        if (s_nxt.state == srctl_pkg::SRCTL_HOLD) begin
            s_nxt.mem_rd = 1'b0;
            s_nxt.timer_start = 1'b0;
        end
    end

    // state register; power-on reset behaves as a held pin reset
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r <= '0;
            s_r.state <= srctl_pkg::SRCTL_HOLD;
            s_r.pins_hiz <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign rdata_out = s_r.rdata;
    assign sys_reset_b_out = s_r.sys_reset_b;
    assign pins_hiz_out = s_r.pins_hiz;
    assign cpu_run_out = s_r.cpu_run;
    assign pc_valid_out = s_r.pc_valid;
    assign pc_out = s_r.pc;
    assign mem_rd_out = s_r.mem_rd;
    assign mem_addr_out = s_r.mem_addr;
    assign ram_hold_out = s_r.ram_hold;

    // a watchdog pulse in run reaches hold at the next edge
    a_wdt_into_reset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_r.state == srctl_pkg::SRCTL_RUN && wdt_overflow_in)
        |=> (!sys_reset_b_out && pins_hiz_out && !cpu_run_out))
        else $error("watchdog overflow did not reset the device");

    // the filtered pin in run reaches hold at the next edge, like the watchdog
    a_pin_into_reset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_r.state == srctl_pkg::SRCTL_RUN && pin_low)
        |=> (!sys_reset_b_out && pins_hiz_out && !cpu_run_out))
        else $error("reset pin did not reset the device");

    // pc is built from the two vector bytes, low first
    a_vector_fetch: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $rose(pc_valid_out) |-> ($past(mem_addr_out, 3) == srctl_pkg::VEC_LO) &&
                                ($past(mem_addr_out, 2) == srctl_pkg::VEC_HI) &&
                                (pc_out == {$past(mem_data_in), $past(mem_data_in, 2)}))
        else $error("program did not start from the reset vector");

    // floating pins beside an active cpu would fight on the board
    a_hiz_no_run: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        pins_hiz_out |-> (!cpu_run_out && !mem_rd_out))
        else $error("pins floated while the cpu was active");

    // the first fetch only follows a completed wait
    a_release_wait: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (mem_rd_out && mem_addr_out == srctl_pkg::VEC_LO) |-> $past(stab.done))
        else $error("vector fetched before stabilization elapsed");

    // leaving hold always restarts the full wait
    a_wdt_self_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_r.state == srctl_pkg::SRCTL_HOLD && !pin_low) |=> stab.start ##1 stab.busy)
        else $error("watchdog reset did not clear and start the wait");

    // no pc is offered while reset is in force
    a_pc_hidden: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !sys_reset_b_out |-> !pc_valid_out)
        else $error("program counter marked valid during reset");

    // the status word stays preset through the wait in cycles without a write
    a_psw_preset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_r.state == srctl_pkg::SRCTL_STAB && !wr_in)
        |=> (s_r.regs[srctl_pkg::OFF_PSW] == 8'h02))
        else $error("program status word not preset");

    // a sample of the presets, seen in every ordinary hold
    a_port_dir_preset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_r.state == srctl_pkg::SRCTL_HOLD && !s_r.stop_hold)
        |=> (s_r.regs[srctl_pkg::OFF_PORT0_DIR] == 8'hFF) &&
            (s_r.regs[srctl_pkg::OFF_OSC_STABILIZE_SELECT] == 8'h04) &&
            (s_r.regs[srctl_pkg::OFF_TXS] == 8'hFF))
        else $error("port direction or clock presets missing");

    // stop reset: contents frozen while the pin is held
    a_stop_frozen: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_r.state == srctl_pkg::SRCTL_HOLD && s_r.stop_hold && pin_low && !wr_in)
        |=> ($stable(s_r.regs) && pins_hiz_out))
        else $error("stop contents changed while reset was held");

    // a new pin event always beats a clear written in the same cycle
    a_cause_set_wins: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        pin_low |=> s_r.cause_pin)
        else $error("pin cause flag lost against a clear");

    // a reset taken from standby keeps the ram until the program runs
    a_ram_hold_standby: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_r.state == srctl_pkg::SRCTL_RUN && reset_req)
        |=> (ram_hold_out == $past(stop_mode_in || halt_mode_in)))
        else $error("ram hold not taken from the standby state");
endmodule

/* File: verif/srctl_reset_src.sv */
// far-side model: external reset pin driver, watchdog overflow source, vector memory
`timescale 1ns/1ps
module srctl_reset_src #(
    parameter int PIN_MIN = 1000,                // minimum low time on the pin, in clocks
    parameter logic [15:0] VEC = 16'h3C5A        // vector contents, arbitrary
) (
    input wire logic clk_in,
    input wire logic pin_req_in,                 // bench asks for the pin to go low
    input wire logic wdt_req_in,                 // bench asks for an overflow
    input wire logic mem_rd_in,
    input wire logic [15:0] mem_addr_in,
    output logic reset_pin_b_out,
    output logic wdt_overflow_out,
    output logic [7:0] mem_data_out
);
    int low_cnt; // cycles the pin has been low so far

    // overflow is a one-cycle pulse from the same clock
    assign wdt_overflow_out = wdt_req_in;

    initial begin
        reset_pin_b_out = 1'b1;
        mem_data_out = 8'h00;
        low_cnt = 0;
    end

    // short requests are stretched so the pin never rises before its minimum width
    always @(posedge clk_in) begin
        if (pin_req_in || (low_cnt != 0 && low_cnt < PIN_MIN)) begin
            reset_pin_b_out <= 1'b0;
            low_cnt <= low_cnt + 1;
        end else begin
            reset_pin_b_out <= 1'b1;
            low_cnt <= 0;
        end
        // byte answers the cycle after a read; otherwise the bus toggles so stale data shows
        if (mem_rd_in) begin
            mem_data_out <= mem_addr_in[0] ? VEC[15:8] : VEC[7:0];
        end else begin
            mem_data_out <= ~mem_data_out;
        end
    end
endmodule

/* File: verif/srctl_top_tb.sv */
// self-checking bench for the system reset controller
`timescale 1ns/1ps
module srctl_top_tb;
    localparam int N = 16;                      // shortened stabilization wait
    localparam int PIN_MIN = 1000;              // ten microseconds at 100 MHz
    localparam logic [15:0] VEC = 16'h3C5A;     // arbitrary vector contents
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic pin_req = 1'b0;
    logic wdt_req = 1'b0;
    logic stop_mode_in = 1'b0;
    logic halt_mode_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic reset_pin_b, wdt_overflow, mem_rd_out, sys_reset_b_out, pins_hiz_out;
    logic cpu_run_out, pc_valid_out, ram_hold_out;
    logic [7:0] mem_data, rdata_out;
    logic [15:0] pc_out, mem_addr_out;
    int mismatches = 0;
    int num_checks = 0;
    int seed = 32'h648b;
    int cycles = 0;
    int n;
    logic [7:0] v;

    always #5 clk_in = ~clk_in;

    srctl_top #(.STAB_CYCLES(N)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .reset_pin_b_in(reset_pin_b), .wdt_overflow_in(wdt_overflow),
        .stop_mode_in(stop_mode_in), .halt_mode_in(halt_mode_in), .mem_data_in(mem_data),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .sys_reset_b_out(sys_reset_b_out),
        .pins_hiz_out(pins_hiz_out), .cpu_run_out(cpu_run_out),
        .pc_valid_out(pc_valid_out), .pc_out(pc_out), .mem_rd_out(mem_rd_out),
        .mem_addr_out(mem_addr_out), .ram_hold_out(ram_hold_out));

    srctl_reset_src #(.PIN_MIN(PIN_MIN), .VEC(VEC)) u_src (.clk_in(clk_in),
        .pin_req_in(pin_req), .wdt_req_in(wdt_req), .mem_rd_in(mem_rd_out),
        .mem_addr_in(mem_addr_out), .reset_pin_b_out(reset_pin_b),
        .wdt_overflow_out(wdt_overflow), .mem_data_out(mem_data));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // preset value of each bank offset, worked out from the reset table
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        case (a)
            8'h00, 8'h10: return 8'h02;
            8'h13: return 8'h04;
            8'h21, 8'h28, 8'h29: return 8'hFF;
            default: return (a >= 8'h09 && a <= 8'h0E) ? 8'hFF : 8'h00;
        endcase
    endfunction

    // stack pointer, byte compare and receive buffer stay undefined
    function automatic bit kept(input logic [7:0] a);
        return a == 8'h01 || a == 8'h02 || a == 8'h18 || a == 8'h22;
    endfunction

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic check_bank;
        logic [7:0] d;
        for (int a = 0; a <= 8'h2C; a++) begin
            if (!kept(8'(a))) begin
                reg_rd(8'(a), d);
                check(16'(d), 16'(exp_reg(8'(a))));
            end
        end
        reg_rd(8'h30, d);
        check(16'(d), 16'h0000); // unmapped offset reads zero
    endtask

    // random writes so that a later preset has something to overwrite
    task automatic scramble;
        logic [7:0] a;
        repeat (12) begin
            a = 8'($unsigned($random(seed)) % 45);
            reg_wr(a, 8'($random(seed)));
        end
    endtask

    task automatic wait_run(output int cnt);
        cnt = 0;
        while (cpu_run_out !== 1'b1 && cnt < 3000) begin
            @(posedge clk_in);
            #1 cnt++;
        end
    endtask

    // overflow pulse, then cycle-by-cycle watch of the hold, wait and vector fetch
    task automatic wdt_reset(input logic standby);
        int k;
        @(posedge clk_in);
        wdt_req <= 1'b1;
        halt_mode_in <= standby;
        @(posedge clk_in);
        wdt_req <= 1'b0;
        halt_mode_in <= 1'b0;
        #1 k = 1;
        check(16'(sys_reset_b_out), 16'h0000);
        check(16'(ram_hold_out), 16'(standby));
        while (cpu_run_out !== 1'b1 && k < 200) begin
            check(16'(pins_hiz_out), 16'(k <= N + 3));
            check(16'(pc_valid_out), 16'h0000);
            @(posedge clk_in);
            #1 k++;
        end
        check(16'(k), 16'(N + 7));
        check(16'({sys_reset_b_out, pc_valid_out}), 16'h0003);
        check(pc_out, VEC);
    endtask

    // pin held low past its minimum width, optionally from stop standby
    task automatic pin_reset(input logic stop, input logic cut);
        @(posedge clk_in);
        stop_mode_in <= stop;
        pin_req <= 1'b1;
        repeat (PIN_MIN + 5) @(posedge clk_in);
        #1 check(16'(pins_hiz_out), 16'h0001);
        check(16'(ram_hold_out), 16'(stop));
        check(16'(cpu_run_out), 16'h0000);
        @(posedge clk_in);
        pin_req <= 1'b0;
        stop_mode_in <= 1'b0;
        if (cut) begin
            repeat (10) @(posedge clk_in);
        end else begin
            wait_run(n);
            check(16'(n >= N + 8 && n <= N + 14), 16'h0001);
            check(pc_out, VEC);
        end
    endtask

    // hang guard, far above the few thousand cycles the sequence needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 60000) begin
            mismatches++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        wait_run(n);
        check(pc_out, VEC);
        check_bank;
        reg_rd(8'h40, v);
        check(16'(v), 16'h00A1);
        reg_wr(8'h41, 8'h03);
        reg_rd(8'h40, v);
        check(16'(v), 16'h00A0);
        reg_wr(8'h13, 8'h02);
        reg_rd(8'h13, v);
        check(16'(v), 16'h0002);
        scramble;
        wdt_reset(1'b0);
        check_bank;
        scramble;
        wdt_reset(1'b1);
        check_bank;
        scramble;
        pin_reset(1'b0, 1'b0);
        check_bank;
        scramble;
        pin_reset(1'b1, 1'b0);
        check_bank;
        pin_reset(1'b0, 1'b1);
        wdt_reset(1'b0);
        tally_and_finish;
    end
endmodule
